// *** hw/bpei_top.sv ***
// Pattern tester receive counters and T1 transmit payload error inserter.
// Assumes the line bit stream arrives as per-bit strobes on sys_clk_i,
// already framed, with framing bit, frame start and channel selection
// marked by the framer; software reaches the registers over APB.
`timescale 1ns/100ps

// Contract
// - Synced: count every received bit, 32 bits
// - Bit counter saturates, sets overflow flag
// - Synced: count every mismatching bit, 24 bits
// - Error counter saturates, sets overflow flag
// - Toggling latch-clear zeroes both counters
// - Alternating words repeat word-count times each
// - Insertion on transmit, T1 mode only
// - Corrupt whole payload or selected channels
// - Invert last bit of each rate sequence
// - Framing bits neither counted nor inverted
// - New rate applies at frame boundary
// - Rate select zero inserts no errors
// - Continuous bit gives unlimited insertion
// - Count-load rising edge starts counted burst
// - Error count is 10 bits, 0 to 1023
// - New count adopted only on load rising edge
// - Count of zero requests no errors
// - Errors-remaining readable at any time
// - Overflow events maskable, shown in info register
module bpei_top
  import bpei_pkg::*;
(
  input wire logic sys_clk_i, // 50 MHz system clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic clk_en_i, // Freezes all state while low.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB enable.
  input wire logic pwrite_i, // APB direction, high for write.
  input wire logic [7:0] paddr_i, // APB byte address.
  input wire logic [31:0] pwdata_i, // APB write data.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error for unmapped address.
  input wire logic t1_mode_i, // High while the line runs T1.
  input wire bpei_rx_line_s rx_line_i, // Received bit stream.
  input wire bpei_tx_line_s tx_line_i, // Transmit bit stream in.
  output bpei_tx_out_s tx_line_o, // Transmit bit stream out.
  output logic rx_sync_o // Registered copy of receive sync.
);

  function automatic logic [RUN_W-1:0] rate_len(
    input logic [RATE_W-1:0] sel
  );
    rate_len = RUN_W'(1) << sel;
  endfunction

  function automatic logic [31:0] word_of(
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    word_of = {16'h0000, hi, lo};
  endfunction

  // Register state.
  logic [CTL_W-1:0] ctl_q;
  logic [7:0] erc_q;
  logic [7:0] awc_q;
  logic [31:0] pat_q;
  logic [NOE_W-1:0] noe_q;
  logic [INF_W-1:0] info_q;

  // Receive side state.
  logic [BITCNT_W-1:0] bitcnt_q;
  logic [ERRCNT_W-1:0] errcnt_q;
  logic [4:0] gen_idx_q;
  logic gen_word_q;
  logic [7:0] gen_rep_q;
  logic sync_q;

  // Transmit side state.
  logic [RATE_W-1:0] rate_act_q;
  logic [RUN_W-1:0] run_q;
  logic [NOE_W-1:0] remain_q;

  // Bus and transmit output state.
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  bpei_tx_out_s tx_q;

  // Bus decode.
  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic rd_ok;

  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i && pready_q;
  assign wr_en = access && pwrite_i;
  assign rd_en = access && !pwrite_i;

  logic wr_ctl;
  logic wr_erc;
  logic lc_toggle;
  logic load_req;
  logic info_read;

  assign wr_ctl = wr_en && (paddr_i == OFS_TESTER_CONTROL_ONE);
  assign wr_erc = wr_en && (paddr_i == OFS_ERROR_RATE_CONTROL);
  assign lc_toggle = wr_ctl &&
    (pwdata_i[CTL_LATCH_CLEAR] != ctl_q[CTL_LATCH_CLEAR]);
  // Only the 0 to 1 edge of the load bit counts, so software must write
  // a zero first to re-arm it.
  assign load_req = wr_erc && pwdata_i[ERC_COUNT_LOAD] &&
    !erc_q[ERC_COUNT_LOAD];
  assign info_read = rd_en && (paddr_i == OFS_TESTER_EVENT_INFO);

  always_comb begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    case (paddr_i)
      OFS_TESTER_CONTROL_ONE: rd_data = {26'h0000000, ctl_q};
      OFS_TESTER_EVENT_INFO: rd_data = {27'h0000000, sync_q, info_q};
      OFS_RECEIVED_BIT_COUNT: rd_data = bitcnt_q;
      OFS_ERRORED_BIT_COUNT: rd_data = {8'h00, errcnt_q};
      OFS_ALT_WORD_REPEAT_COUNT: rd_data = {24'h000000, awc_q};
      OFS_PATTERN: rd_data = pat_q;
      OFS_ERROR_RATE_CONTROL: rd_data = {24'h000000, erc_q};
      OFS_ERROR_COUNT_LOW: rd_data = {24'h000000, noe_q[7:0]};
      OFS_ERROR_COUNT_HIGH: rd_data = {30'h00000000, noe_q[9:8]};
      OFS_ERRORS_REMAINING_LOW: begin
        rd_data = {24'h000000, remain_q[7:0]};
      end
      OFS_ERRORS_REMAINING_HIGH: begin
        rd_data = {30'h00000000, remain_q[9:8]};
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // One wait-free access: the answer is prepared in the setup cycle and
  // ready is raised for exactly the access cycle.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (clk_en_i) begin
      pready_q <= setup;
      pslverr_q <= setup && !rd_ok;
      if (setup && !pwrite_i && rd_ok) begin
        prdata_q <= rd_data;
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_q <= CTL_RST;
      erc_q <= ERC_RST;
      awc_q <= AWC_RST;
      pat_q <= PAT_RST;
      noe_q <= NOE_RST;
    end else if (clk_en_i && wr_en) begin
      case (paddr_i)
        OFS_TESTER_CONTROL_ONE: ctl_q <= pwdata_i[CTL_W-1:0];
        OFS_ALT_WORD_REPEAT_COUNT: awc_q <= pwdata_i[7:0];
        OFS_PATTERN: pat_q <= pwdata_i;
        OFS_ERROR_RATE_CONTROL: erc_q <= pwdata_i[7:0];
        OFS_ERROR_COUNT_LOW: noe_q[7:0] <= pwdata_i[7:0];
        OFS_ERROR_COUNT_HIGH: noe_q[9:8] <= pwdata_i[1:0];
        default: ;
      endcase
    end
  end

  // Receive pattern generator for the expected bit stream.
  logic rx_take;
  logic exp_bit;
  logic [31:0] word_a;
  logic [31:0] word_b;
  logic alt_mode;

  assign rx_take = rx_line_i.valid && rx_line_i.sync;
  assign alt_mode = ctl_q[CTL_ALT_WORD];
  assign word_a = word_of(pat_q[7:0], pat_q[15:8]);
  assign word_b = word_of(pat_q[23:16], pat_q[31:24]);

  always_comb begin
    if (alt_mode) begin
      exp_bit = gen_word_q ? word_b[gen_idx_q[3:0]] :
        word_a[gen_idx_q[3:0]];
    end else begin
      exp_bit = pat_q[gen_idx_q];
    end
  end

  // A repeat count of zero wraps through 255 and so gives 256 words.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen_idx_q <= 5'h00;
      gen_word_q <= 1'b0;
      gen_rep_q <= 8'h00;
    end else if (clk_en_i) begin
      if (!rx_line_i.sync) begin
        gen_idx_q <= 5'h00;
        gen_word_q <= 1'b0;
        gen_rep_q <= 8'h00;
      end else if (rx_take && alt_mode) begin
        gen_idx_q <= {1'b0, gen_idx_q[3:0] + 4'h1};
        if (gen_idx_q[3:0] == 4'hF) begin
          if (gen_rep_q == awc_q - 8'h01) begin
            gen_rep_q <= 8'h00;
            gen_word_q <= !gen_word_q;
          end else begin
            gen_rep_q <= gen_rep_q + 8'h01;
          end
        end
      end else if (rx_take) begin
        gen_idx_q <= gen_idx_q + 5'h01;
      end
    end
  end

  // Receive counters.
  logic bit_full;
  logic err_full;
  logic bit_err;
  logic bit_ovf_ev;
  logic err_ovf_ev;
  logic sync_chg_ev;

  assign bit_full = &bitcnt_q;
  assign err_full = &errcnt_q;
  assign bit_err = rx_take && (rx_line_i.data != exp_bit);
  assign bit_ovf_ev = rx_take && !lc_toggle &&
    (bitcnt_q == {{(BITCNT_W-1){1'b1}}, 1'b0});
  assign err_ovf_ev = bit_err && !lc_toggle &&
    (errcnt_q == {{(ERRCNT_W-1){1'b1}}, 1'b0});
  assign sync_chg_ev = rx_line_i.sync != sync_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bitcnt_q <= '0;
    end else if (clk_en_i) begin
      if (lc_toggle) begin
        bitcnt_q <= '0;
      end else if (rx_take && !bit_full) begin
        bitcnt_q <= bitcnt_q + BITCNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      errcnt_q <= '0;
    end else if (clk_en_i) begin
      if (lc_toggle) begin
        errcnt_q <= '0;
      end else if (bit_err && !err_full) begin
        errcnt_q <= errcnt_q + ERRCNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_q <= 1'b0;
    end else if (clk_en_i) begin
      sync_q <= rx_line_i.sync;
    end
  end

  // Event flags clear on read; an event in the reading cycle survives.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      info_q <= '0;
    end else if (clk_en_i) begin
      if (info_read) begin
        info_q <= '0;
      end
      if (bit_ovf_ev && !ctl_q[CTL_MASK_BIT_OVF]) begin
        info_q[INF_BIT_OVF] <= 1'b1;
      end
      if (err_ovf_ev && !ctl_q[CTL_MASK_ERR_OVF]) begin
        info_q[INF_ERR_OVF] <= 1'b1;
      end
      if (sync_chg_ev && !ctl_q[CTL_MASK_SYNC]) begin
        info_q[INF_SYNC_CHG] <= 1'b1;
      end
      if (bit_err && !ctl_q[CTL_MASK_BIT_ERR]) begin
        info_q[INF_BIT_ERR] <= 1'b1;
      end
    end
  end

  // Transmit error inserter.
  logic eligible;
  logic run_last;
  logic armed;
  logic hit;
  logic continuous;

  assign continuous = erc_q[ERC_CONTINUOUS];
  assign eligible = tx_line_i.valid && t1_mode_i &&
    !tx_line_i.fbit &&
    (!erc_q[ERC_CHAN_ONLY] || tx_line_i.chan_sel);
  assign run_last = run_q == rate_len(rate_act_q) - RUN_W'(1);
  assign armed = (rate_act_q != '0) &&
    (continuous || (remain_q != '0));
  assign hit = eligible && run_last && armed;

  // The rate is only sampled at frame start so a frame is never split
  // between two rates; the run restarts with it.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_act_q <= '0;
      run_q <= '0;
    end else if (clk_en_i) begin
      if (tx_line_i.valid && tx_line_i.frame_start) begin
        rate_act_q <= erc_q[ERC_RATE_LSB +: RATE_W];
        run_q <= '0;
      end else if (eligible) begin
        if (run_last) begin
          run_q <= '0;
        end else begin
          run_q <= run_q + RUN_W'(1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain_q <= '0;
    end else if (clk_en_i) begin
      if (load_req) begin
        remain_q <= noe_q;
      end else if (hit && !continuous) begin
        remain_q <= remain_q - NOE_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_q <= '0;
    end else if (clk_en_i) begin
      tx_q.valid <= tx_line_i.valid;
      tx_q.data <= tx_line_i.data ^ hit;
      tx_q.inverted <= hit;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign tx_line_o = tx_q;
  assign rx_sync_o = sync_q;

endmodule

// *** hw/bpei_pkg.sv ***
// Shared constants and carrier types for the tester counters and the
// transmit payload error inserter.
// Assumes a 32-bit APB slave and a line stream on the same clock.
package bpei_pkg;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OFS_TESTER_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_TESTER_EVENT_INFO = 8'h04;
  localparam logic [7:0] OFS_RECEIVED_BIT_COUNT = 8'h08;
  localparam logic [7:0] OFS_ERRORED_BIT_COUNT = 8'h0C;
  localparam logic [7:0] OFS_ALT_WORD_REPEAT_COUNT = 8'h10;
  localparam logic [7:0] OFS_PATTERN = 8'h14;
  localparam logic [7:0] OFS_ERROR_RATE_CONTROL = 8'h18;
  localparam logic [7:0] OFS_ERROR_COUNT_LOW = 8'h1C;
  localparam logic [7:0] OFS_ERROR_COUNT_HIGH = 8'h20;
  localparam logic [7:0] OFS_ERRORS_REMAINING_LOW = 8'h24;
  localparam logic [7:0] OFS_ERRORS_REMAINING_HIGH = 8'h28;

  // Field positions in tester_control_one.
  localparam int unsigned CTL_LATCH_CLEAR = 0;
  localparam int unsigned CTL_ALT_WORD = 1;
  localparam int unsigned CTL_MASK_BIT_OVF = 2;
  localparam int unsigned CTL_MASK_ERR_OVF = 3;
  localparam int unsigned CTL_MASK_SYNC = 4;
  localparam int unsigned CTL_MASK_BIT_ERR = 5;
  localparam int unsigned CTL_W = 6;

  // Field positions in tester_event_info.
  localparam int unsigned INF_BIT_OVF = 0;
  localparam int unsigned INF_ERR_OVF = 1;
  localparam int unsigned INF_SYNC_CHG = 2;
  localparam int unsigned INF_BIT_ERR = 3;
  localparam int unsigned INF_SYNC_NOW = 4;
  localparam int unsigned INF_W = 4;

  // Field positions in error_rate_control.
  localparam int unsigned ERC_RATE_LSB = 0;
  localparam int unsigned ERC_CONTINUOUS = 4;
  localparam int unsigned ERC_CHAN_ONLY = 5;
  localparam int unsigned ERC_COUNT_LOAD = 7;

  // Widths.
  localparam int unsigned RATE_W = 4;
  localparam int unsigned BITCNT_W = 32;
  localparam int unsigned ERRCNT_W = 24;
  localparam int unsigned NOE_W = 10;
  localparam int unsigned RUN_W = 16;

  // Reset values.
  localparam logic [CTL_W-1:0] CTL_RST = 6'h00;
  localparam logic [7:0] ERC_RST = 8'h00;
  localparam logic [7:0] AWC_RST = 8'h01;
  localparam logic [31:0] PAT_RST = 32'hFFFFFFFF;
  localparam logic [NOE_W-1:0] NOE_RST = 10'h000;

  typedef struct packed {
    logic valid;
    logic data;
    logic fbit;
    logic frame_start;
    logic chan_sel;
  } bpei_tx_line_s;

  typedef struct packed {
    logic valid;
    logic data;
    logic sync;
  } bpei_rx_line_s;

  typedef struct packed {
    logic valid;
    logic data;
    logic inverted;
  } bpei_tx_out_s;

endpackage

// *** verification/bpei_monitor.sv ***
// Port checker for the tester counters and error inserter.
// Assumes it is bound onto bpei_top and sees only its ports.
`timescale 1ns/100ps
module bpei_monitor
  import bpei_pkg::*;
(
  input wire logic sys_clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic clk_en_i, // Clock enable.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB enable.
  input wire logic pwrite_i, // APB direction.
  input wire logic [7:0] paddr_i, // APB address.
  input wire logic [31:0] pwdata_i, // APB write data.
  input wire logic [31:0] prdata_o, // APB read data.
  input wire logic pready_o, // APB ready.
  input wire logic pslverr_o, // APB error.
  input wire logic t1_mode_i, // T1 mode.
  input wire bpei_rx_line_s rx_line_i, // Receive stream.
  input wire bpei_tx_line_s tx_line_i, // Transmit stream in.
  input wire bpei_tx_out_s tx_line_o, // Transmit stream out.
  input wire logic rx_sync_o // Registered sync.
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_OUT_DATA: assert property (clk_en_i && tx_line_i.valid |=>
    tx_line_o.valid &&
    tx_line_o.data == ($past(tx_line_i.data) ^ tx_line_o.inverted))
    else $error("transmit bit not passed or corrupted wrongly");
  AST_OUT_IDLE: assert property (clk_en_i && !tx_line_i.valid |=>
    !tx_line_o.valid) else $error("transmit strobe without input");
  AST_FBIT: assert property (clk_en_i && tx_line_i.valid &&
    tx_line_i.fbit |=> !tx_line_o.inverted)
    else $error("framing bit inverted");
  AST_NOT_T1: assert property (clk_en_i && !t1_mode_i |=>
    !tx_line_o.inverted) else $error("insertion outside T1 mode");
  AST_GAP: assert property (clk_en_i && tx_line_o.inverted |=>
    !tx_line_o.inverted) else $error("two inversions in a row");
  AST_INV_VALID: assert property (tx_line_o.inverted |->
    tx_line_o.valid) else $error("inversion without bit strobe");
  AST_PREADY: assert property (clk_en_i && psel_i && !penable_i
    |=> pready_o ##1 !pready_o) else $error("ready not one cycle");
  AST_SLVERR: assert property (clk_en_i && psel_i && !penable_i &&
    paddr_i > 8'h28 |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  AST_IDLE_BUS: assert property (!pready_o |->
    prdata_o == 32'h0 && !pslverr_o) else $error("bus outputs not idle");

  cover property (tx_line_o.inverted);
  cover property (pslverr_o);
  cover property (rx_line_i.valid && rx_line_i.sync && rx_sync_o);
endmodule

bind bpei_top bpei_monitor bpei_monitor_i (.sys_clk_i, .rst_n_i, .clk_en_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .t1_mode_i, .rx_line_i, .tx_line_i, .tx_line_o,
  .rx_sync_o);

// *** verification/bpei_line.sv ***
// Line-side partner: frames the transmit stream, feeds receive bits.
// Assumes one bit per clock while enabled and a 193-bit T1 frame.
`timescale 1ns/100ps
module bpei_line
  import bpei_pkg::*;
(
  input wire logic clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic rx_en_i, // Send a receive bit.
  input wire logic rx_bit_i, // Receive bit value.
  input wire logic sync_i, // Pattern receiver in sync.
  input wire logic tx_en_i, // Send transmit bits.
  output bpei_rx_line_s rx_line_o, // Receive stream.
  output bpei_tx_line_s tx_line_o // Transmit stream.
);
  logic [7:0] idx_q;
  logic tg_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_q <= 8'h00;
      tg_q <= 1'b0;
    end else begin
      tg_q <= ~tg_q;
      if (!tx_en_i || idx_q == 8'hC0) idx_q <= 8'h00;
      else idx_q <= idx_q + 8'h01;
    end
  end
  // Idle data lines toggle so a stale bit can never look valid.
  always_comb begin
    rx_line_o.valid = rx_en_i;
    rx_line_o.data = rx_en_i ? rx_bit_i : tg_q;
    rx_line_o.sync = sync_i;
    tx_line_o.valid = tx_en_i;
    tx_line_o.data = tx_en_i ? idx_q[1] : tg_q;
    tx_line_o.fbit = (idx_q == 8'h00);
    tx_line_o.frame_start = (idx_q == 8'h00);
    tx_line_o.chan_sel = (idx_q != 8'h00) && (idx_q < 8'h09);
  end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the tester counters and error inserter.
// Assumes bpei_top with the line partner on its stream ports.
`timescale 1ns/100ps
module tb;
  import bpei_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd_q;
  logic pready_o, pslverr_o, rx_sync_o, err_q;
  logic t1_mode_i = 1'b1;
  logic rx_en = 1'b0, rx_bit = 1'b0, sync = 1'b0, tx_en = 1'b0;
  logic clk_en = 1'b1;
  bpei_rx_line_s rx_line_i;
  bpei_tx_line_s tx_line_i;
  bpei_tx_out_s tx_line_o;
  int miscompares = 0, cmp_count = 0, inv_n = 0;

  bpei_top bpei_top_i (.sys_clk_i, .rst_n_i, .clk_en_i(clk_en), .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .t1_mode_i, .rx_line_i, .tx_line_i, .tx_line_o,
    .rx_sync_o);
  bpei_line bpei_line_i (.clk_i(sys_clk_i), .rst_n_i, .rx_en_i(rx_en),
    .rx_bit_i(rx_bit), .sync_i(sync), .tx_en_i(tx_en),
    .rx_line_o(rx_line_i), .tx_line_o(tx_line_i));

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (tx_line_o.valid === 1'b1 && tx_line_o.inverted === 1'b1) inv_n++;
  end

  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // Only the watchdog ends a wait that never sees ready.
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // One idle edge keeps the next call from re-driving psel in this step.
    @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  task automatic rx_send(input int n, input logic b);
    rx_en <= 1'b1;
    rx_bit <= b;
    repeat (n) @(posedge sys_clk_i);
    rx_en <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // Runs two whole frames after loading the rate and the error count.
  task automatic tx_run(input logic [7:0] erc, input logic [9:0] cnt,
                        input logic t1, input int n, input logic [9:0] rem);
    wr(OFS_ERROR_RATE_CONTROL, {24'h0, erc & 8'h7F});
    wr(OFS_ERROR_COUNT_LOW, {24'h0, cnt[7:0]});
    wr(OFS_ERROR_COUNT_HIGH, {30'h0, cnt[9:8]});
    wr(OFS_ERROR_RATE_CONTROL, {24'h0, erc});
    t1_mode_i <= t1;
    inv_n = 0;
    tx_en <= 1'b1;
    repeat (386) @(posedge sys_clk_i);
    tx_en <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk(32'(inv_n), 32'(n));
    rd(OFS_ERRORS_REMAINING_LOW, {24'h0, rem[7:0]});
    rd(OFS_ERRORS_REMAINING_HIGH, {30'h0, rem[9:8]});
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(OFS_TESTER_EVENT_INFO, 32'h0);
    rd(OFS_ALT_WORD_REPEAT_COUNT, 32'h01);
    rd(OFS_PATTERN, 32'hFFFFFFFF);
    rd(OFS_ERROR_RATE_CONTROL, 32'h0);
    rd(8'h3C, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    sync <= 1'b1;
    rx_send(40, 1'b1);
    rd(OFS_RECEIVED_BIT_COUNT, 32'd40);
    rd(OFS_ERRORED_BIT_COUNT, 32'h0);
    rd(OFS_TESTER_EVENT_INFO, 32'h14);
    chk({31'h0, rx_sync_o}, 32'h1);
    rx_send(5, 1'b0);
    rd(OFS_RECEIVED_BIT_COUNT, 32'd45);
    rd(OFS_ERRORED_BIT_COUNT, 32'h5);
    rd(OFS_TESTER_EVENT_INFO, 32'h18);
    wr(OFS_TESTER_CONTROL_ONE, 32'h1);
    rd(OFS_RECEIVED_BIT_COUNT, 32'h0);
    rd(OFS_ERRORED_BIT_COUNT, 32'h0);
    wr(OFS_TESTER_CONTROL_ONE, 32'h20);
    rx_send(3, 1'b0);
    rd(OFS_ERRORED_BIT_COUNT, 32'h3);
    rd(OFS_TESTER_EVENT_INFO, 32'h10);
    sync <= 1'b0;
    wr(OFS_PATTERN, 32'h0000FFFF);
    wr(OFS_ALT_WORD_REPEAT_COUNT, 32'h2);
    wr(OFS_TESTER_CONTROL_ONE, 32'h23);
    sync <= 1'b1;
    rx_send(32, 1'b1);
    rx_send(32, 1'b0);
    rx_send(32, 1'b1);
    rd(OFS_RECEIVED_BIT_COUNT, 32'd96);
    rd(OFS_ERRORED_BIT_COUNT, 32'h0);
    // Bits offered while the clock enable is low must not be counted.
    clk_en <= 1'b0;
    rx_send(8, 1'b1);
    clk_en <= 1'b1;
    rd(OFS_RECEIVED_BIT_COUNT, 32'd96);
    tx_run(8'h14, 10'h000, 1'b1, 24, 10'h000);
    tx_run(8'h10, 10'h000, 1'b1, 0, 10'h000);
    tx_run(8'h14, 10'h000, 1'b0, 0, 10'h000);
    tx_run(8'h33, 10'h000, 1'b1, 2, 10'h000);
    tx_run(8'h84, 10'h003, 1'b1, 3, 10'h000);
    tx_run(8'h84, 10'h000, 1'b1, 0, 10'h000);
    tx_run(8'h84, 10'h3FF, 1'b1, 24, 10'h3E7);
    wr(OFS_ERROR_COUNT_LOW, 32'h05);
    rd(OFS_ERRORS_REMAINING_LOW, 32'hE7);
    wr(OFS_ERROR_RATE_CONTROL, 32'h04);
    wr(OFS_ERROR_RATE_CONTROL, 32'h84);
    rd(OFS_ERRORS_REMAINING_LOW, 32'h05);
    // A rate written in mid-frame waits for the next frame start:
    // 12 inversions at one in 16, then 24 at one in 8.
    wr(OFS_ERROR_RATE_CONTROL, 32'h14);
    inv_n = 0;
    tx_en <= 1'b1;
    repeat (100) @(posedge sys_clk_i);
    wr(OFS_ERROR_RATE_CONTROL, 32'h13);
    do begin
      @(posedge sys_clk_i);
    end while (tx_line_i.frame_start !== 1'b1);
    repeat (192) @(posedge sys_clk_i);
    tx_en <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk(32'(inv_n), 32'd36);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    complete_run();
  end
endmodule
